//--- verilog/sdb_pkg.sv
package sdb_pkg;

  // ****************************************
  // Geometry defaults
  // ****************************************
  localparam int DATA_W_DEF = 8;
  localparam int ROW_W_DEF  = 2;
  localparam int COL_W_DEF  = 4;
  localparam int ADDR_W     = 12;

  // ****************************************
  // Address bit positions
  // ****************************************
  localparam int PRE_SEL_BIT  = 10;
  localparam int BANK_SEL_BIT = 11;

  // ****************************************
  // Mode register layout
  // ****************************************
  localparam int              MR_BL_LSB   = 0;
  localparam int              MR_WRAP_BIT = 3;
  localparam int              MR_CL_LSB   = 4;
  localparam logic [2:0]      BL_FULL     = 3'h7;
  localparam logic [2:0]      CL_ONE      = 3'h1;
  localparam logic [2:0]      CL_TWO      = 3'h2;
  localparam logic [2:0]      CL_LONG     = 3'h3;
  localparam logic [ADDR_W-1:0] MR_RESET  = 12'h020;

  // ****************************************
  // Commands as {row, column, write} strobes
  // ****************************************
  localparam logic [2:0] CMD_MRS   = 3'h0;
  localparam logic [2:0] CMD_REF   = 3'h1;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_STOP  = 3'h6;

  // ****************************************
  // Auto precharge delays in clocks
  // ****************************************
  localparam logic [1:0] AP_DLY_SHORT = 2'h1;
  localparam logic [1:0] AP_DLY_LONG  = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int              CLK_MHZ          = 20;
  localparam int              SREF_INTERVAL_NS = 15625;
  localparam int              SREF_CYCLES      = SREF_INTERVAL_NS * CLK_MHZ / 1000;
  localparam int              SREF_W           = 10;
  localparam logic [SREF_W-1:0] SREF_LAST      = SREF_W'(SREF_CYCLES - 1);

  // ****************************************
  // Power state
  // ****************************************
  typedef enum logic [1:0] {SDB_RUN, SDB_PWRDN, SDB_SELF} sdb_pwr_t;

endpackage

//--- verilog/sdb_mem_if.sv
`timescale 1ns/1ps
interface sdb_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic          re;
  logic          we;
  logic [AW-1:0] raddr;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output re, we, raddr, waddr, wdata, input rdata);
  modport mem  (input re, we, raddr, waddr, wdata, output rdata);
endinterface

//--- verilog/sdb_mem.sv
`timescale 1ns/1ps
module sdb_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Storage port
  sdb_mem_if.mem    mem_bus
);
  import sdb_pkg::*;

  logic [DW-1:0] cell_q [2**AW];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge i_clock) begin
    if (mem_bus.we) begin
      cell_q[mem_bus.waddr] <= mem_bus.wdata;
    end
  end

  // Read data held while frozen
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (mem_bus.re) begin
      rdata_q <= cell_q[mem_bus.raddr];
    end
  end

  assign mem_bus.rdata = rdata_q;
endmodule

//--- verilog/sdb_device.sv
`timescale 1ns/1ps
module sdb_device #(
  parameter int DATA_W = sdb_pkg::DATA_W_DEF,
  parameter int ROW_W  = sdb_pkg::ROW_W_DEF,
  parameter int COL_W  = sdb_pkg::COL_W_DEF
) (
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  // Command pins
  input  wire logic                      i_cke,
  input  wire logic                      i_cs_n,
  input  wire logic                      i_ras_n,
  input  wire logic                      i_cas_n,
  input  wire logic                      i_we_n,
  input  wire logic [sdb_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                      i_dqm,
  // Data pins
  input  wire logic [DATA_W-1:0]         i_dq,
  output logic      [DATA_W-1:0]         o_dq,
  output logic                           o_dq_oe_n,
  // Status
  output logic      [1:0]                o_bank_open,
  output logic                           o_power_down,
  output logic                           o_self_refresh,
  output logic      [ROW_W:0]            o_refresh_ctr,
  output logic                           o_burst_busy
);
  import sdb_pkg::*;

  localparam int AW    = 1 + ROW_W + COL_W;
  localparam int PIN_W = 6 + ADDR_W + DATA_W;
  localparam logic [PIN_W-1:0] PIN_RST = {1'b0, 4'hf, 1'b0, {(ADDR_W + DATA_W){1'b0}}};

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [PIN_W-1:0]  pin_meta_q;
  logic [PIN_W-1:0]  pin_sync_q;
  logic              cke_s;
  logic              cs_n_s;
  logic              ras_n_s;
  logic              cas_n_s;
  logic              we_n_s;
  logic              dqm_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] dq_s;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= PIN_RST;
      pin_sync_q <= PIN_RST;
    end else begin
      pin_meta_q <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dqm, i_addr, i_dq};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, dqm_s, addr_s, dq_s} = pin_sync_q;

  // ****************************************
  // Internal clock enable and decode
  // ****************************************
  sdb_pwr_t   pwr_q;
  sdb_pwr_t   pwr_d;
  logic       clk_en_q;
  logic       run;
  logic       cmd_ok;
  logic [2:0] cmd;
  logic       cmd_act;
  logic       cmd_rd;
  logic       cmd_wr;
  logic       cmd_rw;
  logic       cmd_pre;
  logic       cmd_stop;
  logic       cmd_aref;
  logic       cmd_sref;
  logic       cmd_mrs;
  logic       pre_sel;
  logic       bank_sel;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      clk_en_q <= 1'b0;
    end else begin
      clk_en_q <= cke_s;
    end
  end

  assign run      = clk_en_q && (pwr_q == SDB_RUN);
  assign cmd_ok   = run && !cs_n_s;
  assign cmd      = {ras_n_s, cas_n_s, we_n_s};
  assign cmd_act  = cmd_ok && (cmd == CMD_ACT);
  assign cmd_rd   = cmd_ok && (cmd == CMD_READ);
  assign cmd_wr   = cmd_ok && (cmd == CMD_WRITE);
  assign cmd_rw   = cmd_rd || cmd_wr;
  assign cmd_pre  = cmd_ok && (cmd == CMD_PRE);
  assign cmd_stop = cmd_ok && (cmd == CMD_STOP);
  assign cmd_aref = cmd_ok && (cmd == CMD_REF) && cke_s;
  assign cmd_sref = cmd_ok && (cmd == CMD_REF) && !cke_s;
  assign cmd_mrs  = cmd_ok && (cmd == CMD_MRS);
  assign pre_sel  = addr_s[PRE_SEL_BIT];
  assign bank_sel = addr_s[BANK_SEL_BIT];

  // ****************************************
  // Mode register
  // ****************************************
  logic [ADDR_W-1:0] mr_q;
  logic [2:0]        bl_code;
  logic [2:0]        cl;
  logic              bl_full;
  logic              seq;
  logic [COL_W-1:0]  bl_mask;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mr_q <= MR_RESET;
    end else if (cmd_mrs) begin
      mr_q <= addr_s;
    end
  end

  assign bl_code = mr_q[MR_BL_LSB +: 3];
  assign cl      = mr_q[MR_CL_LSB +: 3];
  assign bl_full = (bl_code == BL_FULL);
  assign seq     = !mr_q[MR_WRAP_BIT] || bl_full;
  assign bl_mask = bl_full ? '1 : COL_W'((32'd1 << bl_code) - 32'd1);

  // ****************************************
  // Power state
  // ****************************************
  logic bank_open_q [2];
  logic bst_act_q;
  logic pd_q;
  logic sr_q;

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      SDB_RUN: begin
        if (cmd_sref) begin
          pwr_d = SDB_SELF;
        end else if (clk_en_q && !cke_s && !bank_open_q[0] && !bank_open_q[1]
                     && !bst_act_q && !cmd_act) begin
          pwr_d = SDB_PWRDN;
        end
      end
      SDB_PWRDN, SDB_SELF: begin
        if (cke_s) begin
          pwr_d = SDB_RUN;
        end
      end
      default: pwr_d = SDB_RUN;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pwr_q <= SDB_RUN;
      pd_q  <= 1'b0;
      sr_q  <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      pd_q  <= (pwr_d == SDB_PWRDN);
      sr_q  <= (pwr_d == SDB_SELF);
    end
  end

  // ****************************************
  // Burst engine
  // ****************************************
  logic             bst_wr_q;
  logic             bst_bank_q;
  logic             bst_ap_q;
  logic [COL_W-1:0] bst_start_q;
  logic [COL_W-1:0] bst_cnt_q;
  logic             pre_hit;
  logic             beat_now;
  logic [COL_W-1:0] beat_cnt;
  logic [COL_W-1:0] beat_start;
  logic [COL_W-1:0] beat_col;
  logic             beat_wr;
  logic             beat_bank;
  logic             beat_ap;
  logic             beat_last;
  logic [ROW_W-1:0] row_q [2];

  assign pre_hit    = cmd_pre && bst_act_q && (pre_sel || bank_sel == bst_bank_q);
  assign beat_now   = cmd_rw || (run && bst_act_q && !cmd_stop && !pre_hit);
  assign beat_cnt   = cmd_rw ? '0 : bst_cnt_q;
  assign beat_start = cmd_rw ? addr_s[COL_W-1:0] : bst_start_q;
  assign beat_wr    = cmd_rw ? cmd_wr : bst_wr_q;
  assign beat_bank  = cmd_rw ? bank_sel : bst_bank_q;
  assign beat_ap    = cmd_rw ? pre_sel : bst_ap_q;
  assign beat_last  = !bl_full && (beat_cnt == bl_mask);
  assign beat_col   = (beat_start & ~bl_mask)
                    | ((seq ? beat_start + beat_cnt : beat_start ^ beat_cnt) & bl_mask);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bst_act_q   <= 1'b0;
      bst_wr_q    <= 1'b0;
      bst_bank_q  <= 1'b0;
      bst_ap_q    <= 1'b0;
      bst_start_q <= '0;
      bst_cnt_q   <= '0;
    end else if (beat_now) begin
      bst_act_q <= !beat_last;
      bst_cnt_q <= beat_cnt + COL_W'(1);
      if (cmd_rw) begin
        bst_wr_q    <= cmd_wr;
        bst_bank_q  <= bank_sel;
        bst_ap_q    <= pre_sel;
        bst_start_q <= addr_s[COL_W-1:0];
      end
    end else if (run && (cmd_stop || pre_hit)) begin
      bst_act_q <= 1'b0;
    end
  end

  // ****************************************
  // Auto precharge timer
  // ****************************************
  logic [1:0] ap_cnt_q;
  logic       ap_bank_q;
  logic       ap_fire;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ap_cnt_q  <= 2'h0;
      ap_bank_q <= 1'b0;
    end else if (run) begin
      if (beat_now && beat_last && beat_ap) begin
        ap_cnt_q  <= (cl == CL_LONG) ? AP_DLY_LONG : AP_DLY_SHORT;
        ap_bank_q <= beat_bank;
      end else if (ap_cnt_q != 2'h0) begin
        ap_cnt_q <= ap_cnt_q - 2'h1;
      end
    end
  end

  assign ap_fire = run && (ap_cnt_q == 2'h1);

  // ****************************************
  // Bank state
  // ****************************************
  for (genvar b = 0; b < 2; b++) begin : g_bank
    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        bank_open_q[b] <= 1'b0;
        row_q[b]       <= '0;
      end else if (cmd_act && bank_sel == 1'(b)) begin
        bank_open_q[b] <= 1'b1;
        row_q[b]       <= addr_s[ROW_W-1:0];
      end else if (cmd_pre && (pre_sel || bank_sel == 1'(b))) begin
        bank_open_q[b] <= 1'b0;
      end else if (ap_fire && ap_bank_q == 1'(b)) begin
        bank_open_q[b] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Refresh counter and self refresh timer
  // ****************************************
  logic [ROW_W:0]    ref_ctr_q;
  logic [SREF_W-1:0] sref_cnt_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_ctr_q  <= '0;
      sref_cnt_q <= '0;
    end else if (pwr_q == SDB_SELF) begin
      if (sref_cnt_q == SREF_LAST) begin
        sref_cnt_q <= '0;
        ref_ctr_q  <= ref_ctr_q + (ROW_W + 1)'(1);
      end else begin
        sref_cnt_q <= sref_cnt_q + SREF_W'(1);
      end
    end else begin
      sref_cnt_q <= '0;
      if (cmd_aref) begin
        ref_ctr_q <= ref_ctr_q + (ROW_W + 1)'(1);
      end
    end
  end

  // ****************************************
  // Storage and read pipeline
  // ****************************************
  sdb_mem_if #(.AW(AW), .DW(DATA_W)) mem_bus ();

  assign mem_bus.re    = run;
  assign mem_bus.raddr = {beat_bank, row_q[beat_bank], beat_col};
  assign mem_bus.waddr = {beat_bank, row_q[beat_bank], beat_col};
  assign mem_bus.we    = beat_now && beat_wr && !dqm_s;
  assign mem_bus.wdata = dq_s;

  sdb_mem #(.AW(AW), .DW(DATA_W)) u_mem (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .mem_bus (mem_bus)
  );

  logic [2:0]        rv_q;
  logic [DATA_W-1:0] dp0_q;
  logic [DATA_W-1:0] dp1_q;
  logic              dqm_d_q;
  logic [DATA_W-1:0] dq_q;
  logic              dq_oe_n_q;
  logic [DATA_W-1:0] sel_data;
  logic              sel_valid;

  always_comb begin
    case (cl)
      CL_ONE: begin
        sel_data  = mem_bus.rdata;
        sel_valid = rv_q[0];
      end
      CL_TWO: begin
        sel_data  = dp0_q;
        sel_valid = rv_q[1];
      end
      default: begin
        sel_data  = dp1_q;
        sel_valid = rv_q[2];
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rv_q      <= 3'h0;
      dp0_q     <= '0;
      dp1_q     <= '0;
      dqm_d_q   <= 1'b0;
      dq_q      <= '0;
      dq_oe_n_q <= 1'b1;
    end else if (run) begin
      rv_q      <= {rv_q[1:0], beat_now && !beat_wr};
      dp0_q     <= mem_bus.rdata;
      dp1_q     <= dp0_q;
      dqm_d_q   <= dqm_s;
      dq_q      <= sel_data;
      dq_oe_n_q <= !(sel_valid && !dqm_d_q);
    end else if (pwr_q != SDB_RUN) begin
      dq_oe_n_q <= 1'b1;
    end
  end

  assign o_dq           = dq_q;
  assign o_dq_oe_n      = dq_oe_n_q;
  assign o_bank_open    = {bank_open_q[1], bank_open_q[0]};
  assign o_power_down   = pd_q;
  assign o_self_refresh = sr_q;
  assign o_refresh_ctr  = ref_ctr_q;
  assign o_burst_busy   = bst_act_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_read_mask;
    run && dqm_s ##1 run |=> dq_oe_n_q;
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("masked read still driven");

  property p_write_mask;
    dqm_s |-> !mem_bus.we;
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("masked write stored");

  property p_auto_ref;
    cmd_aref |=> ref_ctr_q == (ROW_W + 1)'($past(ref_ctr_q) + 1);
  endproperty
  a_auto_ref: assert property (p_auto_ref) else $error("refresh counter not stepped");

  property p_self_entry;
    cmd_sref |=> sr_q && !mem_bus.we && !bst_act_q;
  endproperty
  a_self_entry: assert property (p_self_entry) else $error("self refresh not entered");

  property p_pwrdn_hold;
    pd_q ##1 pd_q |-> $stable(ref_ctr_q) && !cmd_ok;
  endproperty
  a_pwrdn_hold: assert property (p_pwrdn_hold) else $error("activity in power down");

  property p_pre_all;
    cmd_pre && pre_sel |=> !bank_open_q[0] && !bank_open_q[1];
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_pre_one;
    cmd_pre && !pre_sel && bank_open_q[!bank_sel] && !ap_fire
      |=> !bank_open_q[$past(bank_sel)] && bank_open_q[!$past(bank_sel)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("wrong bank precharged");

  property p_stop;
    cmd_stop && bank_open_q[0] && !ap_fire |=> !bst_act_q && bank_open_q[0];
  endproperty
  a_stop: assert property (p_stop) else $error("burst stop misbehaved");

  property p_suspend;
    !run |=> $stable(bst_cnt_q) && $stable(dq_q) && $stable(bst_act_q);
  endproperty
  a_suspend: assert property (p_suspend) else $error("state moved while frozen");

  property p_full;
    bl_full && bst_act_q && run && !cmd_stop && !pre_hit |=> bst_act_q;
  endproperty
  a_full: assert property (p_full) else $error("full page burst ended");

  property p_restart;
    cmd_rw && !bl_full && bl_mask != '0 |=> bst_act_q && bst_cnt_q == COL_W'(1);
  endproperty
  a_restart: assert property (p_restart) else $error("burst not restarted");

  c_auto_ref: cover property (cmd_aref);
  c_self_exit: cover property (sr_q ##1 !sr_q);
  c_full_wrap: cover property (bl_full && bst_act_q && bst_cnt_q == '1 ##1 bst_act_q);
  c_pwrdn: cover property (!pd_q ##1 pd_q);
endmodule

//--- verif/sdb_ctl_model.sv
`timescale 1ns/1ps
module sdb_ctl_model (
  // Clock
  input  wire logic        i_clock,
  // Device pins
  output logic             o_cke,
  output logic             o_cs_n,
  output logic [2:0]       o_cmd,
  output logic [11:0]      o_addr,
  output logic             o_dqm,
  output logic [7:0]       o_dq
);
  import sdb_pkg::*;

  initial begin
    o_cke  = 1'h1;
    o_cs_n = 1'h0;
    o_cmd  = 3'h7;
    o_addr = 12'h000;
    o_dqm  = 1'h0;
    o_dq   = 8'h00;
  end

  // ****************************************
  // One command cycle with data, mask, enable
  // ****************************************
  task automatic issue(input logic [2:0] c, input logic [11:0] a, input logic [7:0] d,
                       input logic m, input logic k);
    @(posedge i_clock);
    o_cmd  <= c;
    o_addr <= a;
    o_dq   <= d;
    o_dqm  <= m;
    o_cke  <= k;
  endtask

  // One command with chip select high, then back to no-op
  task automatic deselect(input logic [2:0] c, input logic [11:0] a);
    @(posedge i_clock);
    o_cs_n <= 1'h1;
    o_cmd  <= c;
    o_addr <= a;
    @(posedge i_clock);
    o_cs_n <= 1'h0;
    o_cmd  <= 3'h7;
  endtask

  // Released data lines toggle so no stale value survives
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clock);
      o_cmd <= 3'h7;
      o_dqm <= 1'h0;
      o_dq  <= ~o_dq;
    end
  endtask
endmodule

//--- verif/sdram_burst_refresh_precharge_bench.sv
`timescale 1ns/1ps
module sdram_burst_refresh_precharge_bench;
  import sdb_pkg::*;

  typedef struct packed {
    logic       b;
    logic [3:0] col;
    logic [7:0] wd;
    logic       m;
    logic [7:0] exp;
  } sdb_row_t;

  logic        i_clock;
  logic        i_rst;
  logic        cke;
  logic        cs_n;
  logic [2:0]  cmd;
  logic [11:0] addr;
  logic        dqm;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic        oe_n;
  logic [1:0]  bank_open;
  logic        pd;
  logic        sr;
  logic [2:0]  ctr;
  logic [2:0]  ctr_save;
  logic        busy;
  logic [7:0]  beats [8];
  int          lows;
  int          err_count;
  int          checks_done;
  sdb_row_t    rows [5] = '{'{1'h0, 4'h1, 8'h5a, 1'h0, 8'h5a}, '{1'h0, 4'h2, 8'hc3, 1'h0, 8'hc3},
                           '{1'h1, 4'h3, 8'h0f, 1'h0, 8'h0f}, '{1'h0, 4'h4, 8'h11, 1'h0, 8'h11},
                           '{1'h0, 4'h4, 8'haa, 1'h1, 8'h11}};

  sdb_ctl_model u_ctl (.i_clock(i_clock), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd),
                       .o_addr(addr), .o_dqm(dqm), .o_dq(dq_in));

  sdb_device u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_cke(cke), .i_cs_n(cs_n),
                    .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_addr(addr),
                    .i_dqm(dqm), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe_n(oe_n),
                    .o_bank_open(bank_open), .o_power_down(pd), .o_self_refresh(sr),
                    .o_refresh_ctr(ctr), .o_burst_busy(busy));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    #1;
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts driven beats over a span of no-ops and keeps the data of the first eight
  task automatic watch(input int n);
    lows = 0;
    repeat (n) begin
      u_ctl.idle(1);
      #1;
      if (oe_n === 1'h0) begin
        if (lows < 8) beats[lows] = dq_out;
        lows++;
      end
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    $display("Error watchdog expected done seen hang");
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_count = 0;
    checks_done = 0;
    i_rst = 1'h1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'h0;
    check("rst_oe", {oe_n, bank_open, pd, sr, ctr, busy}, 12'h100);
    u_ctl.idle(4000);
    u_ctl.issue(CMD_PRE, 12'h400, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(6);
    repeat (2) begin
      u_ctl.issue(CMD_REF, 12'h000, 8'h00, 1'h0, 1'h1);
      u_ctl.idle(8);
    end
    check("ref_ctr", ctr, 12'h002);
    u_ctl.issue(CMD_MRS, 12'h020, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_ACT, 12'h001, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(4);
    u_ctl.issue(CMD_ACT, 12'h802, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(6);
    check("open", bank_open, 12'h003);
    foreach (rows[i]) begin
      u_ctl.issue(CMD_WRITE, {rows[i].b, 7'h00, rows[i].col}, rows[i].wd, rows[i].m, 1'h1);
      u_ctl.idle(6);
      u_ctl.issue(CMD_READ, {rows[i].b, 7'h00, rows[i].col}, 8'h00, 1'h0, 1'h1);
      watch(12);
      check("row_beats", lows, 12'h001);
      check("row_data", beats[0], rows[i].exp);
    end
    u_ctl.issue(CMD_MRS, 12'h022, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h1, 1'h1);
    watch(12);
    check("mask_beats", lows, 12'h003);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_READ, 12'h004, 8'h00, 1'h0, 1'h1);
    watch(14);
    check("restart_beats", lows, 12'h005);
    check("restart_data", beats[1], 12'h011);
    u_ctl.issue(CMD_WRITE, 12'h000, 8'h21, 1'h0, 1'h1);
    u_ctl.issue(3'h7, 12'h000, 8'h22, 1'h0, 1'h1);
    u_ctl.issue(CMD_STOP, 12'h000, 8'h23, 1'h0, 1'h1);
    u_ctl.idle(6);
    check("stop_open", {bank_open[0], busy}, 12'h002);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    watch(12);
    check("stop_data0", beats[0], 12'h021);
    check("stop_data1", beats[1], 12'h022);
    check("stop_drop", beats[2], 12'h0c3);
    u_ctl.issue(CMD_MRS, 12'h027, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(30);
    check("full_busy", busy, 12'h001);
    u_ctl.issue(CMD_STOP, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(6);
    check("full_end", busy, 12'h000);
    u_ctl.issue(CMD_MRS, 12'h022, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h0, 1'h0);
    u_ctl.idle(10);
    check("susp_busy", busy, 12'h001);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(10);
    check("susp_end", busy, 12'h000);
    u_ctl.issue(CMD_PRE, 12'h800, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(6);
    check("pre_b", bank_open, 12'h001);
    u_ctl.deselect(CMD_ACT, 12'h802);
    u_ctl.idle(6);
    check("cs_ignore", bank_open, 12'h001);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h1, 1'h1);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h1, 1'h1);
    u_ctl.issue(CMD_WRITE, 12'h000, 8'h44, 1'h1, 1'h1);
    watch(12);
    check("turn_beats", lows, 12'h000);
    u_ctl.issue(CMD_READ, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_PRE, 12'h000, 8'h00, 1'h0, 1'h1);
    watch(12);
    check("pre_cut", {lows < 4, bank_open}, 12'h004);
    u_ctl.issue(CMD_MRS, 12'h020, 8'h00, 1'h0, 1'h1);
    u_ctl.issue(CMD_ACT, 12'h802, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(6);
    u_ctl.issue(CMD_WRITE, 12'hc05, 8'h77, 1'h0, 1'h1);
    u_ctl.idle(6);
    check("ap_write", bank_open, 12'h000);
    u_ctl.issue(CMD_ACT, 12'h802, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(6);
    u_ctl.issue(CMD_READ, 12'hc05, 8'h00, 1'h0, 1'h1);
    watch(12);
    check("ap_read", {beats[0], bank_open}, 12'h1dc);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h0, 1'h0);
    u_ctl.idle(4);
    check("pd_in", pd, 12'h001);
    ctr_save = ctr;
    u_ctl.idle(400);
    check("pd_noref", ctr, ctr_save);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(4);
    check("pd_out", pd, 12'h000);
    u_ctl.issue(CMD_REF, 12'h000, 8'h00, 1'h0, 1'h0);
    u_ctl.idle(4);
    check("sr_in", sr, 12'h001);
    u_ctl.issue(CMD_ACT, 12'h001, 8'h00, 1'h0, 1'h0);
    ctr_save = ctr;
    u_ctl.idle(700);
    check("sr_ctr", ctr, 3'(ctr_save + 3'h2));
    check("sr_ignore", bank_open, 12'h000);
    u_ctl.issue(3'h7, 12'h000, 8'h00, 1'h0, 1'h1);
    u_ctl.idle(10);
    check("sr_out", sr, 12'h000);
    finish_test();
  end
endmodule
